// ==== src/epg_regs.vh ====
`ifndef EPG_REGS_VH
`define EPG_REGS_VH
// Clock period in ns
`define EPG_CLK_NS        10
// Initial pulse, nominal 1 ms, in ns and in cycles
`define EPG_PULSE_NS      1000000
`define EPG_PULSE_CYC     24'h0186a0
// Overprogram pulse per initial pulse, 3 ms
`define EPG_OVER_NS       3000000
`define EPG_OVER_CYC      24'h0493e0
// Data valid after gate low, 150 ns max
`define EPG_TOE_NS        150
`define EPG_TOE_CYC       24'h00000f
// Gate to float delay, 130 ns max
`define EPG_TDF_NS        130
`define EPG_TDF_CYC       24'h00000d
// Setup and hold, 2 us
`define EPG_SETUP_NS      2000
`define EPG_SETUP_CYC     24'h0000c8
// Most initial pulses per byte
`define EPG_MAX_TRIES     5'h19
// Counter width
`define EPG_CW            24
`endif

// ==== src/epg_timer.v ====
`timescale 1ns/1ps
// Down counter; done in the last cycle of the loaded interval
module epg_timer (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        load,
    input  wire [23:0] value,
    output wire        done
);
    reg [23:0] count_reg;

    // Counts down and holds at zero
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= 24'h000000;
        end else if (load) begin
            count_reg <= value;
        end else if (count_reg != 24'h000000) begin
            count_reg <= count_reg - 24'h000001;
        end
    end

    // Done must not look at load: load is built from done upstream
    assign done = (count_reg <= 24'h000001);
endmodule // epg_timer

// ==== src/epg_programmer.v ====
`timescale 1ns/1ps
// Behaviour
// - Program: supply raised, select low, data
// - 1 ms pulses, then 3X ms overprogram
// - Initial pulse 0.95 to 1.05 ms
// - Overprogram pulse 2.85 to 78.75 ms
// - Final readback compare at 5 V; not done here, S_OVER goes straight to S_END
// - Parallel: only selected chip programs
// - Standard verify: gate low, select high
// - Optional verify: gate and select low
// - Shared bus: verify at read level; here PIN_VPP_HIGH and PIN_VCC_HIGH stay raised through verify
// - Signature entered by raised PIN_SIG_HIGH line
// - Signature: other address lines held low
// - Wait data valid and float delays
`include "epg_regs.vh"
module epg_programmer (
    CLOCK,
    NRST,
    START,
    OP,
    ADDR,
    WDATA,
    OPT_VERIFY,
    BUSY,
    DONE,
    FAIL,
    RDATA,
    TRIES,
    PIN_ADDR,
    PIN_SIG_HIGH,
    PIN_CE_N,
    PIN_OE_N,
    PIN_VPP_HIGH,
    PIN_VCC_HIGH,
    PIN_DATA_IN,
    PIN_DATA_OUT,
    PIN_DATA_OE_N
);
    input  wire        CLOCK;
    input  wire        NRST;
    input  wire        START;
    input  wire [1:0]  OP;
    input  wire [14:0] ADDR;
    input  wire [7:0]  WDATA;
    input  wire        OPT_VERIFY;
    output wire        BUSY;
    output reg         DONE;
    output reg         FAIL;
    output reg  [7:0]  RDATA;
    output reg  [4:0]  TRIES;
    output reg  [14:0] PIN_ADDR;
    output reg         PIN_SIG_HIGH;
    output reg         PIN_CE_N;
    output reg         PIN_OE_N;
    output reg         PIN_VPP_HIGH;
    output reg         PIN_VCC_HIGH;
    input  wire [7:0]  PIN_DATA_IN;
    output reg  [7:0]  PIN_DATA_OUT;
    output reg         PIN_DATA_OE_N;

    // Operations
    localparam [1:0] OP_PROG = 2'h0;
    localparam [1:0] OP_READ = 2'h1;
    localparam [1:0] OP_SIG  = 2'h2;
    // States
    localparam [3:0] S_IDLE  = 4'h0;
    localparam [3:0] S_SETUP = 4'h1;
    localparam [3:0] S_PULSE = 4'h2;
    localparam [3:0] S_HOLD  = 4'h3;
    localparam [3:0] S_VOE   = 4'h4;
    localparam [3:0] S_VSAMP = 4'h5;
    localparam [3:0] S_FLOAT = 4'h6;
    localparam [3:0] S_OVER  = 4'h7;
    localparam [3:0] S_RSET  = 4'h8;
    localparam [3:0] S_END   = 4'h9;

    reg        rs1_reg;
    reg        rs2_reg;
    wire       rst_n;
    reg  [3:0] state_reg;
    reg  [1:0] op_reg;
    reg        opt_reg;
    reg        tload;
    reg [23:0] tval;
    wire       tdone;

    // Reset released through two flops
    always @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            rs1_reg <= 1'b0;
            rs2_reg <= 1'b0;
        end else begin
            rs1_reg <= 1'b1;
            rs2_reg <= rs1_reg;
        end
    end
    assign rst_n = rs2_reg;

    epg_timer u_timer (
        .clk   (CLOCK),
        .rst_n (rst_n),
        .load  (tload),
        .value (tval),
        .done  (tdone)
    );

    assign BUSY = (state_reg != S_IDLE);

    // Timer loads on each state entry except the return to S_IDLE
    always @* begin
        tload = 1'b0;
        tval  = 24'h000000;
        case (state_reg)
            S_IDLE: begin
                tload = START;
                tval  = `EPG_SETUP_CYC;
            end
            S_SETUP: begin
                tload = tdone;
                tval  = (op_reg == OP_PROG) ? `EPG_PULSE_CYC
                                             : `EPG_TOE_CYC;
            end
            S_PULSE, S_OVER: begin
                tload = tdone;
                tval  = `EPG_SETUP_CYC;
            end
            S_HOLD, S_VOE: begin
                tload = tdone;
                tval  = 24'h000001;
            end
            // Gate low long enough for valid data
            S_RSET: begin
                tload = tdone;
                tval  = `EPG_TOE_CYC;
            end
            S_VSAMP: begin
                tload = 1'b1;
                tval  = `EPG_TDF_CYC;
            end
            S_FLOAT: begin
                tload = tdone;
                tval  = (RDATA == PIN_DATA_OUT)
                        ? `EPG_OVER_CYC * TRIES : `EPG_PULSE_CYC;
            end
            default: begin
                tload = 1'b0;
                tval  = 24'h000000;
            end
        endcase
    end

    // Main sequencer
    always @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            state_reg     <= S_IDLE;
            op_reg        <= OP_PROG;
            opt_reg       <= 1'b0;
            DONE          <= 1'b0;
            FAIL          <= 1'b0;
            RDATA         <= 8'h00;
            TRIES         <= 5'h00;
            PIN_ADDR      <= 15'h0000;
            PIN_SIG_HIGH  <= 1'b0;
            PIN_CE_N      <= 1'b1;
            PIN_OE_N      <= 1'b1;
            PIN_VPP_HIGH  <= 1'b0;
            PIN_VCC_HIGH  <= 1'b0;
            PIN_DATA_OUT  <= 8'hff;
            PIN_DATA_OE_N <= 1'b1;
        end else begin
            DONE <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    if (START) begin
                        op_reg  <= OP;
                        opt_reg <= OPT_VERIFY;
                        FAIL    <= 1'b0;
                        TRIES   <= 5'h00;
                        PIN_OE_N <= 1'b1;
                        if (OP == OP_SIG) begin
                            PIN_ADDR     <= {14'h0000, ADDR[0]};
                            PIN_SIG_HIGH <= 1'b1;
                        end else begin
                            PIN_ADDR <= ADDR;
                        end
                        if (OP == OP_PROG) begin
                            PIN_VPP_HIGH  <= 1'b1;
                            PIN_VCC_HIGH  <= 1'b1;
                            PIN_DATA_OUT  <= WDATA;
                            PIN_DATA_OE_N <= 1'b0;
                        end else begin
                            PIN_VPP_HIGH <= 1'b0;
                            PIN_VCC_HIGH <= 1'b0;
                        end
                        state_reg <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    if (tdone) begin
                        if (op_reg == OP_PROG) begin
                            PIN_CE_N  <= 1'b0;
                            TRIES     <= TRIES + 5'h01;
                            state_reg <= S_PULSE;
                        end else begin
                            PIN_CE_N  <= 1'b0;
                            PIN_OE_N  <= 1'b0;
                            state_reg <= S_VOE;
                        end
                    end
                end
                S_PULSE: begin
                    if (tdone) begin
                        PIN_CE_N  <= 1'b1;
                        state_reg <= S_HOLD;
                    end
                end
                S_HOLD: begin
                    // Data hold before releasing the bus
                    if (tdone) begin
                        PIN_DATA_OE_N <= 1'b1;
                        state_reg     <= S_RSET;
                    end
                end
                S_RSET: begin
                    if (tdone) begin
                        PIN_OE_N  <= 1'b0;
                        PIN_CE_N  <= ~opt_reg;
                        state_reg <= S_VOE;
                    end
                end
                S_VOE: begin
                    if (tdone) begin
                        state_reg <= S_VSAMP;
                    end
                end
                S_VSAMP: begin
                    RDATA     <= PIN_DATA_IN;
                    PIN_OE_N  <= 1'b1;
                    PIN_CE_N  <= 1'b1;
                    state_reg <= S_FLOAT;
                end
                S_FLOAT: begin
                    if (tdone) begin
                        if (op_reg != OP_PROG) begin
                            state_reg <= S_END;
                        end else if (RDATA == PIN_DATA_OUT) begin
                            PIN_DATA_OE_N <= 1'b0;
                            PIN_CE_N      <= 1'b0;
                            state_reg     <= S_OVER;
                        end else if (TRIES == `EPG_MAX_TRIES) begin
                            FAIL      <= 1'b1;
                            state_reg <= S_END;
                        end else begin
                            PIN_DATA_OE_N <= 1'b0;
                            PIN_CE_N      <= 1'b0;
                            TRIES         <= TRIES + 5'h01;
                            state_reg     <= S_PULSE;
                        end
                    end
                end
                S_OVER: begin
                    if (tdone) begin
                        PIN_CE_N      <= 1'b1;
                        state_reg     <= S_END;
                    end
                end
                default: begin
                    // Drop supplies and leave the bus idle
                    PIN_DATA_OE_N <= 1'b1;
                    PIN_VPP_HIGH  <= 1'b0;
                    PIN_VCC_HIGH  <= 1'b0;
                    PIN_SIG_HIGH  <= 1'b0;
                    PIN_CE_N      <= 1'b1;
                    PIN_OE_N      <= 1'b1;
                    DONE          <= 1'b1;
                    state_reg     <= S_IDLE;
                end
            endcase
        end
    end
endmodule // epg_programmer

// ==== bench/epg_programmer_properties.sv ====
`timescale 1ns/1ps
module epg_programmer_properties (
    input wire        CLOCK,
    input wire        NRST,
    input wire        FAIL,
    input wire [4:0]  TRIES,
    input wire        OPT_VERIFY,
    input wire [14:0] PIN_ADDR,
    input wire        PIN_SIG_HIGH,
    input wire        PIN_CE_N,
    input wire        PIN_OE_N,
    input wire        PIN_VPP_HIGH,
    input wire [7:0]  PIN_DATA_OUT,
    input wire        PIN_DATA_OE_N
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    reg [23:0] ce_cnt_reg;
    reg [7:0]  oe_cnt_reg;
    // Low-time counters; pulses are far past any repetition count
    always @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            ce_cnt_reg <= 24'h0;
            oe_cnt_reg <= 8'h0;
        end else begin
            ce_cnt_reg <= PIN_CE_N ? 24'h0 : ce_cnt_reg + 24'h1;
            oe_cnt_reg <= PIN_OE_N ? 8'h0 : oe_cnt_reg + 8'h1;
        end
    end
    sequence s_prog_pulse_end;
        $rose(PIN_CE_N) && $stable(PIN_OE_N) && PIN_VPP_HIGH && PIN_OE_N;
    endsequence
    sequence s_undriven;
        PIN_DATA_OE_N [*8];
    endsequence
    a_pulse_width_ok: assert property (s_prog_pulse_end |->
        (ce_cnt_reg >= 24'h17318 && ce_cnt_reg <= 24'h19a28) ||
        (ce_cnt_reg >= 24'h45948 && ce_cnt_reg <= 24'h7829b8))
        else $error("program pulse width out of range");
    a_bus_released: assert property (!PIN_OE_N |-> PIN_DATA_OE_N)
        else $error("host drives data while gate low");
    a_prog_data_held: assert property (
        !PIN_CE_N && PIN_OE_N && PIN_VPP_HIGH |->
        !PIN_DATA_OE_N && $stable(PIN_DATA_OUT))
        else $error("program data not held during pulse");
    a_verify_select: assert property (
        !PIN_OE_N && PIN_VPP_HIGH |-> PIN_CE_N == !OPT_VERIFY)
        else $error("wrong select level in verify");
    a_sig_addr_low: assert property (
        PIN_SIG_HIGH |-> PIN_ADDR[14:1] == 14'h0)
        else $error("address lines high in signature mode");
    a_data_valid_wait: assert property (
        $rose(PIN_OE_N) |-> oe_cnt_reg >= 8'h0f)
        else $error("gate low shorter than data valid delay");
    a_float_wait: assert property ($rose(PIN_OE_N) |-> s_undriven)
        else $error("data driven inside float delay");
    a_fail_count: assert property ($rose(FAIL) |-> TRIES == 5'h19)
        else $error("failure flagged at wrong pulse count");
endmodule // epg_programmer_properties
bind epg_programmer epg_programmer_properties i_epg_programmer_properties (
    .CLOCK, .NRST, .FAIL, .TRIES, .OPT_VERIFY, .PIN_ADDR, .PIN_SIG_HIGH,
    .PIN_CE_N, .PIN_OE_N, .PIN_VPP_HIGH, .PIN_DATA_OUT, .PIN_DATA_OE_N);

// ==== bench/epg_device.sv ====
`timescale 1ns/1ps
module epg_device #(
    parameter [7:0] MAKER_ID = 8'h5a,  // Arbitrary value
    parameter [7:0] PART_ID  = 8'h3c   // Arbitrary value
) (
    input  wire        ce_n,
    input  wire        oe_n,
    input  wire        vpp_high,
    input  wire        sig_high,
    input  wire [14:0] addr,
    input  wire [7:0]  bus,
    output wire [7:0]  q
);
    reg  [7:0] mem [0:32767];
    reg  [7:0] last;
    reg        valid;
    integer    k;
    wire       drive;
    wire [7:0] val;
    initial begin
        for (k = 0; k < 32768; k = k + 1) mem[k] = 8'hff;
        last = 8'h00;
        valid = 1'b0;
    end
    assign drive = !oe_n && (vpp_high || !ce_n);
    assign val = sig_high ? (addr[0] ? PART_ID : MAKER_ID) : mem[addr];
    // valid late; a floating bus shows the inverse, not a held value
    always @(drive) begin
        valid = 1'b0;
        if (drive) valid <= #140 1'b1;
    end
    always @* if (valid) last = val;
    assign q = valid ? val : ~last;
    // end of select pulse only clears bits
    always @(posedge ce_n) if (vpp_high && oe_n) mem[addr] <= mem[addr] & bus;
endmodule // epg_device

// ==== bench/epg_programmer_test.sv ====
`timescale 1ns/1ps
module epg_programmer_test;
    localparam [7:0] MAKER_ID = 8'h5a;  // Arbitrary value
    localparam [7:0] PART_ID  = 8'h3c;  // Arbitrary value
    reg         clock, nrst, start, opt_verify;
    reg  [1:0]  op;
    reg  [14:0] addr;
    reg  [7:0]  wdata;
    wire        busy, done, fail, sig_h, ce_n, oe_n, vpp_h, vcc_h, doe_n;
    wire [7:0]  rdata, dout, dev_q, data_bus;
    wire [4:0]  tries;
    wire [14:0] pin_addr;
    integer     mismatches, n_tests, n, b;
    // Bus level: host wins only while its enable is low
    assign data_bus = doe_n ? dev_q : dout;
    epg_programmer i_epg_programmer (.CLOCK(clock), .NRST(nrst),
        .START(start), .OP(op), .ADDR(addr), .WDATA(wdata),
        .OPT_VERIFY(opt_verify), .BUSY(busy), .DONE(done), .FAIL(fail),
        .RDATA(rdata), .TRIES(tries), .PIN_ADDR(pin_addr),
        .PIN_SIG_HIGH(sig_h), .PIN_CE_N(ce_n), .PIN_OE_N(oe_n),
        .PIN_VPP_HIGH(vpp_h), .PIN_VCC_HIGH(vcc_h), .PIN_DATA_IN(data_bus),
        .PIN_DATA_OUT(dout), .PIN_DATA_OE_N(doe_n));
    epg_device #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID)) i_epg_device (
        .ce_n(ce_n), .oe_n(oe_n), .vpp_high(vpp_h), .sig_high(sig_h),
        .addr(pin_addr), .bus(data_bus), .q(dev_q));
    task stop_test;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, mismatches);
            if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task check(input [23:0] seen, input [23:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("wrong value at %0t: %h expected %h", $time, seen, exp);
            end
        end
    endtask
    function cur(input integer sel);
        cur = sel == 0 ? done : (sel == 1 ? ce_n : oe_n);
    endfunction
    // Bounded wait, counts the cycles spent
    task wait_for(input integer sel, input val, input integer lim);
        begin
            n = 0;
            while (cur(sel) !== val && n < lim) begin
                @(negedge clock);
                n = n + 1;
            end
            if (cur(sel) !== val) begin
                mismatches = mismatches + 1;
                stop_test;
            end
        end
    endtask
    task run_op(input [1:0] o, input [14:0] a, input [7:0] d);
        begin
            op = o;
            addr = a;
            wdata = d;
            start = 1'b1;
            @(negedge clock);
            start = 1'b0;
        end
    endtask
    // Erased read with a refused second request, then a stored byte
    task read_scn;
        begin
            i_epg_device.mem[15'h0155] = 8'h3a;
            run_op(2'h1, 15'h7fff, 8'h00);
            @(negedge clock);
            run_op(2'h1, 15'h0155, 8'h00);
            wait_for(0, 1'b1, 1000);
            check(rdata, 8'hff);
            repeat (300) @(negedge clock);
            check(busy, 1'b0);
            run_op(2'h1, 15'h0155, 8'h00);
            wait_for(0, 1'b1, 1000);
            check(rdata, 8'h3a);
        end
    endtask
    // Both identifier bytes
    task sig_scn;
        begin
            for (b = 0; b < 2; b = b + 1) begin
                run_op(2'h2, {14'h0, b[0]}, 8'h00);
                wait_for(0, 1'b1, 1000);
                check(rdata, b ? PART_ID : MAKER_ID);
            end
        end
    endtask
    // One initial pulse, optional verify, then abort by reset mid-run
    task prog_scn;
        begin
            opt_verify = 1'b1;
            run_op(2'h0, 15'h0042, 8'h5c);
            wait_for(1, 1'b0, 1000);
            check({vpp_h, vcc_h, doe_n, dout}, {3'b110, 8'h5c});
            wait_for(1, 1'b1, 110000);
            check(n, 24'h186a0);
            wait_for(2, 1'b0, 1000);
            check(i_epg_device.mem[15'h0042], 8'h5c);
            check(ce_n, 1'b0);
            check({fail, tries}, {1'b0, 5'h01});
            wait_for(2, 1'b1, 100);
            nrst = 1'b0;
            repeat (3) @(negedge clock);
            check({ce_n, oe_n, vpp_h, doe_n}, 4'hd);
            nrst = 1'b1;
            repeat (4) @(negedge clock);
            run_op(2'h1, 15'h0042, 8'h00);
            wait_for(0, 1'b1, 1000);
            check({vpp_h, vcc_h, rdata}, {2'b00, 8'h5c});
        end
    endtask
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        nrst = 1'b0;
        start = 1'b0;
        opt_verify = 1'b0;
        op = 2'h0;
        addr = 15'h0;
        wdata = 8'h00;
        mismatches = 0;
        n_tests = 0;
        repeat (8) @(negedge clock);
        nrst = 1'b1;
        repeat (4) @(negedge clock);
        read_scn;
        sig_scn;
        prog_scn;
        stop_test;
    end
endmodule // epg_programmer_test
